//--- rtl/ufc_flow_ctrl.sv
// UART flow control core: register slave, CTS monitor, RTS driver, transmit pacing.
// Assumes classic Wishbone on core_clk and a receive/transmit datapath on the same clock.
// How it works
// - Transmit waits for asserted CTS under flow control.
// - Flow enable gives CTS and RTS to hardware.
// - Select zero: drop RTS at full queue.
// - Select one: drop RTS at threshold or more.
// - Send back to back while CTS and data.
// - Finish current character, then wait for CTS.
// - Flow control raises no queue interrupts.
// - Pin register shows current CTS level.
// - Pin register RTS bit drives, reads RTS.
// - Every monitored CTS change sets flag; enable gates request.
// - Change flag stays until one written.
// - CTS monitoring off while baud clock off.
// - Low-power bit 22 selects dual-edge sampling.
// - Low-power bit 21 selects half-step divisor.
// - Bit 20 gates clock when fully idle.
// - Bit 19 reads baud clock ready.
// - Independent register set, 0x00 to 0x34; 0x18, 0x20 and 0x38 read zero.
// - Every reset source returns fields to reset.
// - Receive queue depth is eight.
// - CTS sampling disable, bit 7, resets one.
// - Release select bit 14, enable bit 13.
`default_nettype none
module ufc_flow_ctrl #(
   parameter bit LOW_POWER = 1'b1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   input wire logic periphReset,
   // Wishbone slave.
   input wire ufc_pkg::ufc_wb_req_t wbReq,
   output logic [31:0] wbDatO,
   output logic wbAck,
   // Handshake pins, active low.
   input wire logic ctsPin_n,
   output logic rtsPin_n,
   // Datapath status.
   input wire logic [3:0] rxLevel,
   input wire logic [3:0] txLevel,
   input wire logic rxBusy,
   input wire logic baudClkStable,
   // Transmit shifter control.
   input wire logic txQueueValid,
   input wire logic txCharDone,
   output logic txStart,
   // System outputs.
   output logic irq,
   output logic clkGateOn,
   output logic [22:0] ctrlCfg
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdData;
      logic [22:0] ctrl;
      logic [31:0] intEn;
      logic ctsFlag;
      logic pinRts;
      logic ctsSeen;
      logic irq;
      logic rtsPin;
      logic clkGate;
      logic bclkRdy;
      logic [ufc_pkg::N_PLAIN-1:0][31:0] plain;
   } ufc_state_t;

   localparam ufc_state_t ST_RST = '{
      ctrl: ufc_pkg::CTRL_RST,
      pinRts: 1'b1,
      rtsPin: 1'b1,
      default: '0
   };

   ufc_state_t st_r;
   ufc_state_t st_nxt;
   logic ctsLevel;
   logic txBusy;
   logic access;
   logic wr;
   logic [31:0] mask;
   logic [22:0] ctrlMask;
   logic [31:0] rdWord;
   logic monitorOn;
   logic ctsAsserted;
   logic rtsDrop;
   logic ctsClear;
   logic txPermit;

   // CTS comes from another device and is filtered before anything looks at it.
   ufc_pin_sync #(
      .RST_LEVEL(1'b1)
   ) ctsSync (
      .core_clk(core_clk),
      .reset(reset),
      .pinIn(ctsPin_n),
      .level(ctsLevel)
   );

   // Only characters not yet started are held back, so a dropped CTS never tears a frame.
   ufc_tx_pacer txPacer (
      .core_clk(core_clk),
      .reset(reset),
      .permit(txPermit),
      .queueValid(txQueueValid),
      .charDone(txCharDone),
      .start(txStart),
      .busy(txBusy)
   );

   // Bus decode terms and the control write mask.
   always_comb begin
      access = wbReq.cyc && wbReq.stb && !st_r.ack;
      wr = access && wbReq.we;
      mask = ufc_pkg::selMask(wbReq.sel);
      ctrlMask = ufc_pkg::CTRL_WMASK;
      if (!LOW_POWER) begin
         ctrlMask = ufc_pkg::CTRL_WMASK & ~ufc_pkg::CTRL_LPMASK;
      end
   end

   // Flow control terms derived from the current state.
   always_comb begin
      monitorOn = st_r.ctrl[ufc_pkg::B_BCLKEN] && !st_r.ctrl[ufc_pkg::B_CTS_DIS];
      ctsAsserted = !ctsLevel;
      txPermit = !st_r.ctrl[ufc_pkg::B_HFC_EN] || st_r.ctsSeen;
      if (st_r.ctrl[ufc_pkg::B_RTSDC]) begin
         rtsDrop = rxLevel >= st_r.ctrl[ufc_pkg::B_THD +: 4];
      end else begin
         rtsDrop = rxLevel == ufc_pkg::RX_DEPTH;
      end
      ctsClear = wr && (wbReq.adr == ufc_pkg::OFS_INT_FLAGS)
         && wbReq.sel[0] && wbReq.dat[ufc_pkg::B_CTS_CHANGE_EVENT];
   end

   // Read multiplexer; unmapped offsets answer with zero.
   always_comb begin
      rdWord = 32'h0000_0000;
      unique case (wbReq.adr)
         ufc_pkg::OFS_CTRL: begin
            rdWord[22:0] = st_r.ctrl;
            rdWord[ufc_pkg::B_BCLKRDY] = st_r.bclkRdy;
         end
         ufc_pkg::OFS_LINE_STATUS: begin
            rdWord[ufc_pkg::B_RX_LVL +: 4] = rxLevel;
            rdWord[ufc_pkg::B_TX_LVL +: 4] = txLevel;
         end
         ufc_pkg::OFS_INT_EN: rdWord = st_r.intEn;
         ufc_pkg::OFS_INT_FLAGS: rdWord[ufc_pkg::B_CTS_CHANGE_EVENT] = st_r.ctsFlag;
         ufc_pkg::OFS_BAUD_DIV: rdWord = st_r.plain[0];
         ufc_pkg::OFS_OVERSAMPLE: rdWord = st_r.plain[1];
         ufc_pkg::OFS_PIN_CTRL: begin
            rdWord[ufc_pkg::B_PIN_CTS] = ctsLevel;
            rdWord[ufc_pkg::B_PIN_RTS] = st_r.rtsPin;
         end
         ufc_pkg::OFS_XFER_CTRL: rdWord = st_r.plain[2];
         ufc_pkg::OFS_WAKE_EN: rdWord = st_r.plain[3];
         default: rdWord = 32'h0000_0000;
      endcase
   end

   // Next state: register writes, CTS monitor, RTS and clock gating.
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = access;
      if (access) begin
         st_nxt.rdData = rdWord;
      end
      if (wr) begin
         unique case (wbReq.adr)
            ufc_pkg::OFS_CTRL: begin
               st_nxt.ctrl = (st_r.ctrl & ~(mask[22:0] & ctrlMask))
                  | (wbReq.dat[22:0] & mask[22:0] & ctrlMask);
            end
            ufc_pkg::OFS_INT_EN: begin
               st_nxt.intEn = (st_r.intEn & ~mask) | (wbReq.dat & mask);
            end
            ufc_pkg::OFS_BAUD_DIV: begin
               st_nxt.plain[0] = (st_r.plain[0] & ~mask) | (wbReq.dat & mask);
            end
            ufc_pkg::OFS_OVERSAMPLE: begin
               st_nxt.plain[1] = (st_r.plain[1] & ~mask) | (wbReq.dat & mask);
            end
            ufc_pkg::OFS_PIN_CTRL: begin
               if (wbReq.sel[0]) begin
                  st_nxt.pinRts = wbReq.dat[ufc_pkg::B_PIN_RTS];
               end
            end
            ufc_pkg::OFS_XFER_CTRL: begin
               st_nxt.plain[2] = (st_r.plain[2] & ~mask) | (wbReq.dat & mask);
            end
            ufc_pkg::OFS_WAKE_EN: begin
               st_nxt.plain[3] = (st_r.plain[3] & ~mask) | (wbReq.dat & mask);
            end
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end
      // The monitor freezes its last seen level while off, so re-enabling cannot fake a change.
      if (monitorOn) begin
         st_nxt.ctsSeen = ctsAsserted;
      end
      // A change in the same cycle as the clearing write wins over the clear.
      st_nxt.ctsFlag = (monitorOn && (ctsAsserted != st_r.ctsSeen))
         || (st_r.ctsFlag && !ctsClear);
      st_nxt.irq = st_r.ctsFlag && st_r.intEn[ufc_pkg::B_CTS_CHANGE_EVENT];
      if (st_r.ctrl[ufc_pkg::B_HFC_EN]) begin
         st_nxt.rtsPin = rtsDrop;
      end else begin
         st_nxt.rtsPin = st_r.pinRts;
      end
      st_nxt.bclkRdy = st_r.ctrl[ufc_pkg::B_BCLKEN] && baudClkStable;
      st_nxt.clkGate = st_r.ctrl[ufc_pkg::B_UCAGM] && !txBusy && !txQueueValid
         && !rxBusy;
      // The peripheral reset clears fields like the system reset but keeps the bus answering.
      if (periphReset) begin
         st_nxt = ST_RST;
         st_nxt.ack = access;
      end
   end

   // Each instance keeps its own copy of the whole register set.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from state flops.
   assign wbAck = st_r.ack;
   assign wbDatO = st_r.rdData;
   assign rtsPin_n = st_r.rtsPin;
   assign irq = st_r.irq;
   assign clkGateOn = st_r.clkGate;
   assign ctrlCfg = st_r.ctrl;

   // Full queue drops RTS one cycle later when the full-depth release is chosen.
   rtsFull_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_HFC_EN] && !st_r.ctrl[ufc_pkg::B_RTSDC]
      && rxLevel == ufc_pkg::RX_DEPTH |=> rtsPin_n)
      else $error("RTS not released at full receive queue.");

   // Threshold release holds RTS high while the level stays at or above it.
   rtsThresh_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_HFC_EN] && st_r.ctrl[ufc_pkg::B_RTSDC]
      && rxLevel >= st_r.ctrl[ufc_pkg::B_THD +: 4] |=> rtsPin_n)
      else $error("RTS asserted above the receive threshold.");

   // Below a full queue the full-depth release asserts RTS.
   rtsAssert_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_HFC_EN] && !st_r.ctrl[ufc_pkg::B_RTSDC]
      && rxLevel < ufc_pkg::RX_DEPTH |=> !rtsPin_n)
      else $error("RTS held off with room in the receive queue.");

   // Without flow control the pin follows the software bit.
   rtsSoft_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.ctrl[ufc_pkg::B_HFC_EN] |=> rtsPin_n == $past(st_r.pinRts))
      else $error("RTS pin does not follow the pin control bit.");

   // A monitored CTS change sets the flag on the next edge.
   ctsFlagSet_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      monitorOn && ctsAsserted != st_r.ctsSeen |=> st_r.ctsFlag)
      else $error("CTS change missed by the change flag.");

   // The flag stays until a one is written to it.
   ctsFlagHold_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctsFlag && !ctsClear |=> st_r.ctsFlag)
      else $error("CTS change flag dropped without a clearing write.");

   // With the enable clear no request reaches the output.
   irqMask_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.intEn[ufc_pkg::B_CTS_CHANGE_EVENT] |=> !irq)
      else $error("Interrupt raised while masked.");

   // With the baud clock off the monitor neither moves nor flags.
   ctsOff_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.ctrl[ufc_pkg::B_BCLKEN] && !st_r.ctsFlag |=> $stable(st_r.ctsSeen) && !st_r.ctsFlag)
      else $error("CTS monitored while the baud clock is off.");

   // Under flow control no start follows a deasserted CTS.
   txHold_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_HFC_EN] && !st_r.ctsSeen |=> !txStart)
      else $error("Character started while CTS is deasserted.");

   // Ready reads as one only while the baud clock is enabled and stable.
   bclkRdy_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.ctrl[ufc_pkg::B_BCLKEN] |=> !st_r.bclkRdy)
      else $error("Baud clock ready while disabled.");

   // Reserved upper control bits answer zero.
   rsvdZero_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      access && !wbReq.we && wbReq.adr == ufc_pkg::OFS_CTRL |=> wbDatO[31:23] == 9'h000)
      else $error("Reserved control bits read non-zero.");

   // A pending change with its enable set requests the interrupt on the next edge.
   irqSet_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctsFlag && st_r.intEn[ufc_pkg::B_CTS_CHANGE_EVENT] |=> irq)
      else $error("Enabled CTS change not requested.");

   // The CTS change flag is the only interrupt source; queue state never raises one.
   irqSource_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.ctsFlag |=> !irq)
      else $error("Interrupt raised without a CTS change.");

   // A clearing write with no new change in the same cycle empties the flag.
   ctsFlagClr_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      ctsClear && !(monitorOn && ctsAsserted != st_r.ctsSeen) |=> !st_r.ctsFlag)
      else $error("CTS change flag survived its clearing write.");

   // Below the threshold the threshold release asserts RTS.
   rtsBelow_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_HFC_EN] && st_r.ctrl[ufc_pkg::B_RTSDC]
      && rxLevel < st_r.ctrl[ufc_pkg::B_THD +: 4] |=> !rtsPin_n)
      else $error("RTS held off below the receive threshold.");

   // The CTS bit of a pin register read is the filtered pin level.
   pinCtsRead_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      access && !wbReq.we && wbReq.adr == ufc_pkg::OFS_PIN_CTRL
      |=> wbDatO[ufc_pkg::B_PIN_CTS] == $past(ctsLevel))
      else $error("Pin control read shows a stale CTS level.");

   // The RTS bit of a pin register read is the level on the RTS pin.
   pinRtsRead_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      access && !wbReq.we && wbReq.adr == ufc_pkg::OFS_PIN_CTRL
      |=> wbDatO[ufc_pkg::B_PIN_RTS] == $past(rtsPin_n))
      else $error("Pin control read shows a stale RTS level.");

   // Ready follows an enabled and stable baud clock one edge later.
   bclkRdyOn_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      st_r.ctrl[ufc_pkg::B_BCLKEN] && baudClkStable |=> st_r.bclkRdy)
      else $error("Baud clock ready missing while enabled and stable.");

   // Without auto gating the UART clock is never paused.
   noGate_a: assert property (@(posedge core_clk) disable iff (reset || periphReset)
      !st_r.ctrl[ufc_pkg::B_UCAGM] |=> !clkGateOn)
      else $error("UART clock gated with auto gating off.");
endmodule : ufc_flow_ctrl
`default_nettype wire

//--- rtl/ufc_pkg.sv
// Shared constants and types for the UART flow control block.
// Assumes a single core clock domain and a classic Wishbone register slave.
`default_nettype none
package ufc_pkg;
   // Register byte offsets.
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_LINE_STATUS = 6'h04;
   localparam logic [5:0] OFS_INT_EN = 6'h08;
   localparam logic [5:0] OFS_INT_FLAGS = 6'h0C;
   localparam logic [5:0] OFS_BAUD_DIV = 6'h10;
   localparam logic [5:0] OFS_OVERSAMPLE = 6'h14;
   localparam logic [5:0] OFS_TX_LOOK = 6'h18;
   localparam logic [5:0] OFS_PIN_CTRL = 6'h1C;
   localparam logic [5:0] OFS_QUEUE_DATA = 6'h20;
   localparam logic [5:0] OFS_XFER_CTRL = 6'h30;
   localparam logic [5:0] OFS_WAKE_EN = 6'h34;
   localparam logic [5:0] OFS_WAKE_FLAGS = 6'h38;
   // Control field positions.
   localparam int CTRL_W = 23;
   localparam int B_THD = 0;
   localparam int B_CTS_DIS = 7;
   localparam int B_HFC_EN = 13;
   localparam int B_RTSDC = 14;
   localparam int B_BCLKEN = 15;
   localparam int B_BCLKRDY = 19;
   localparam int B_UCAGM = 20;
   localparam int B_FDM = 21;
   localparam int B_DESM = 22;
   localparam logic [22:0] CTRL_RST = 23'h000080;
   localparam logic [22:0] CTRL_WMASK = 23'h77FCFF;
   localparam logic [22:0] CTRL_LPMASK = 23'h640000;
   // Status, interrupt and pin field positions.
   localparam int B_RX_LVL = 8;
   localparam int B_TX_LVL = 12;
   localparam int B_CTS_CHANGE_EVENT = 5;
   localparam int B_PIN_CTS = 0;
   localparam int B_PIN_RTS = 1;
   localparam logic [3:0] RX_DEPTH = 4'h8;
   // Plain storage words: divisor, oversample, transfer engine, wakeup enable.
   localparam int N_PLAIN = 4;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [5:0] adr;
      logic [31:0] dat;
   } ufc_wb_req_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ufc_tx_state_t;
   // Expands byte selects into a bit mask.
   function automatic logic [31:0] selMask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction : selMask
endpackage : ufc_pkg
`default_nettype wire

//--- rtl/ufc_pin_sync.sv
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to core_clk.
`default_nettype none
module ufc_pin_sync #(
   parameter logic RST_LEVEL = 1'b1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Pin and filtered level.
   input wire logic pinIn,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } ufc_sync_state_t;
   localparam ufc_sync_state_t SYNC_RST = '{RST_LEVEL, RST_LEVEL, RST_LEVEL, RST_LEVEL};
   ufc_sync_state_t st_r;
   ufc_sync_state_t st_nxt;
   // The first stage feeds only the second; a level counts once stages two and three agree.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pinIn;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.lvl = st_r.s3;
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r <= SYNC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign level = st_r.lvl;
endmodule : ufc_pin_sync
`default_nettype wire

//--- rtl/ufc_tx_pacer.sv
// Decides when the transmit shifter may start its next character.
// Assumes the shifter pulses charDone once at the end of each character it was started on.
`default_nettype none
module ufc_tx_pacer (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Start conditions.
   input wire logic permit,
   input wire logic queueValid,
   input wire logic charDone,
   // Shifter control.
   output logic start,
   output logic busy
);
   typedef struct packed {
      ufc_pkg::ufc_tx_state_t fsm;
      logic start;
   } ufc_pacer_state_t;
   localparam ufc_pacer_state_t PACER_RST = '{ufc_pkg::TX_IDLE, 1'b0};
   ufc_pacer_state_t st_r;
   ufc_pacer_state_t st_nxt;
   // A character in flight always runs to its end; the permit is looked at only between them.
   always_comb begin
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      unique case (st_r.fsm)
         ufc_pkg::TX_IDLE: begin
            if (permit && queueValid) begin
               st_nxt.fsm = ufc_pkg::TX_SEND;
               st_nxt.start = 1'b1;
            end
         end
         ufc_pkg::TX_SEND: begin
            if (charDone) begin
               st_nxt.fsm = ufc_pkg::TX_IDLE;
            end
         end
         default: st_nxt.fsm = ufc_pkg::TX_IDLE;
      endcase
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r <= PACER_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign start = st_r.start;
   assign busy = st_r.fsm == ufc_pkg::TX_SEND;
   // A start is only ever issued from a permitted idle cycle.
   startPermit_a: assert property (@(posedge core_clk) disable iff (reset)
      start |-> $past(permit) && $past(queueValid))
      else $error("Transmit started without permission.");
   // The shifter is never cut short by a dropped permit.
   charHold_a: assert property (@(posedge core_clk) disable iff (reset)
      busy && !charDone |=> busy)
      else $error("Character abandoned before completion.");
endmodule : ufc_tx_pacer
`default_nettype wire

//--- verif/ufc_far_uart.sv
// Behavioural far-end UART that receives our characters and paces us with CTS.
// Assumes one character reaches it per txStart pulse, all on the core clock.
`default_nettype none
module ufc_far_uart #(
   parameter int CAP = 3,
   parameter int DRAIN = 7
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Character arrival and bench commands.
   input wire logic charIn,
   input wire logic stall,
   input wire logic hold,
   // Handshake pin toward the block, active low.
   output logic ctsPin_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int fill;
   int tick;
   logic drain;

   // A stalled reader keeps its queue, which models a slow far end.
   assign drain = !stall && fill > 0 && tick == DRAIN - 1;

   // Receive queue of the far end: fills per character, empties at the drain rate.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fill <= 0;
         tick <= 0;
      end else begin
         tick <= (tick == DRAIN - 1) ? 0 : tick + 1;
         fill <= fill + int'(charIn) - int'(drain);
      end
   end

   // CTS drops while the queue is full or the bench holds it off, and returns with space.
   assign ctsPin_n = hold || (fill >= CAP);
endmodule : ufc_far_uart
`default_nettype wire

//--- verif/tb_ufc_flow_ctrl.sv
// Self-checking bench for the UART flow control core.
// Assumes ufc_pkg and the far-end model are compiled first; one 25 MHz clock.
`default_nettype none
module tb_ufc_flow_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SHIFT_LEN = 20;
   typedef struct packed {
      logic we;
      logic [5:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ufc_row_t;
   logic core_clk = 1'b0, reset = 1'b1, periphReset = 1'b0, wbAck, ctsPin_n, rtsPin_n;
   logic rxBusy = 1'b0, baudClkStable = 1'b1, txQueueValid = 1'b0, txCharDone = 1'b0;
   logic txStart, irq, clkGateOn, stall = 1'b1, hold = 1'b0;
   logic [31:0] wbDatO;
   logic [3:0] rxLevel = 4'h3, txLevel = 4'h5;
   logic [22:0] ctrlCfg;
   ufc_pkg::ufc_wb_req_t wbReq = '0;
   int failures = 0, numChecks = 0, startCnt = 0, shiftCnt = 0;
   // Register rows: a write carries its data, a read carries the expected word.
   ufc_row_t rows [13] = '{
      '{1'b0, ufc_pkg::OFS_CTRL, 4'hF, 32'h00000080},
      '{1'b1, ufc_pkg::OFS_CTRL, 4'hF, 32'hFFFFFFFF},
      '{1'b0, ufc_pkg::OFS_CTRL, 4'hF, 32'h007FFCFF},
      '{1'b0, ufc_pkg::OFS_LINE_STATUS, 4'hF, 32'h00005300},
      '{1'b1, ufc_pkg::OFS_BAUD_DIV, 4'h3, 32'h12345678},
      '{1'b0, ufc_pkg::OFS_BAUD_DIV, 4'hF, 32'h00005678},
      '{1'b1, ufc_pkg::OFS_WAKE_EN, 4'hF, 32'hA5A5A5A5},
      '{1'b0, ufc_pkg::OFS_WAKE_EN, 4'hF, 32'hA5A5A5A5},
      '{1'b1, ufc_pkg::OFS_TX_LOOK, 4'hF, 32'hFFFFFFFF},
      '{1'b0, ufc_pkg::OFS_TX_LOOK, 4'hF, 32'h00000000},
      '{1'b0, 6'h24, 4'hF, 32'h00000000},
      '{1'b1, ufc_pkg::OFS_INT_EN, 4'hF, 32'h00000020},
      '{1'b0, ufc_pkg::OFS_INT_EN, 4'hF, 32'h00000020}};
   logic [31:0] flCtrl [4] = '{32'h00008000, 32'h00008000, 32'h00008080, 32'h00000000};
   logic [31:0] flEn [4] = '{32'h00000020, 32'h00000000, 32'h00000020, 32'h00000020};
   logic [31:0] flExp [4] = '{32'h00000020, 32'h00000020, 32'h00000000, 32'h00000000};
   logic [31:0] rtCtrl [5] = '{32'h0000A000, 32'h0000A000, 32'h0000E003, 32'h0000E003,
                               32'h0000E003};
   logic [3:0] rtLvl [5] = '{4'h7, 4'h8, 4'h2, 4'h3, 4'h8};
   logic rtExp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

   ufc_flow_ctrl i_ufc_flow_ctrl (.core_clk(core_clk), .reset(reset),
      .periphReset(periphReset), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
      .ctsPin_n(ctsPin_n), .rtsPin_n(rtsPin_n), .rxLevel(rxLevel), .txLevel(txLevel),
      .rxBusy(rxBusy), .baudClkStable(baudClkStable), .txQueueValid(txQueueValid),
      .txCharDone(txCharDone), .txStart(txStart), .irq(irq), .clkGateOn(clkGateOn),
      .ctrlCfg(ctrlCfg));
   ufc_far_uart i_ufc_far_uart (.core_clk(core_clk), .reset(reset), .charIn(txStart),
      .stall(stall), .hold(hold), .ctsPin_n(ctsPin_n));

   // Clock at 40 ns period.
   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // Shifter stand-in: each started character takes SHIFT_LEN cycles, then reports done.
   always @(posedge core_clk) begin
      txCharDone <= 1'b0;
      if (shiftCnt != 0) begin
         shiftCnt <= shiftCnt - 1;
         if (shiftCnt == 1) txCharDone <= 1'b1;
      end else if (txStart === 1'b1) begin
         shiftCnt <= SHIFT_LEN;
         startCnt <= startCnt + 1;
      end
   end

   task automatic testDone;
      $display("Checks %0d, failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : testDone

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cycles

   // One classic cycle; held until ack is sampled high, released at that edge.
   task automatic wbXfer(input logic we, input logic [5:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rd);
      int n;
      @(posedge core_clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
      for (n = 0; n < 20; n++) begin
         @(posedge core_clk);
         if (wbAck === 1'b1) break;
      end
      rd = wbDatO;
      wbReq <= '0;
      if (n == 20) begin
         failures++;
         $display("Error wbAck expected 1 seen timeout");
         testDone();
      end
   endtask : wbXfer

   task automatic wr(input logic [5:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wbXfer(1'b1, adr, 4'hF, dat, d);
   endtask : wr

   task automatic rdChk(input string name, input logic [5:0] adr, input logic [31:0] mask,
                        input logic [31:0] exp);
      logic [31:0] d;
      wbXfer(1'b0, adr, 4'hF, 32'h0, d);
      check(name, exp, d & mask);
   endtask : rdChk

   // Main sequence: reset, register rows, then the handshake cases.
   initial begin
      cycles(6);
      reset <= 1'b0;
      @(posedge core_clk);
      check("ctrlCfg", 32'h00000080, {9'h0, ctrlCfg});
      check("rtsPin_n", 32'h1, {31'h0, rtsPin_n});
      check("irq", 32'h0, {31'h0, irq});
      $display("Test reset done");
      foreach (rows[i]) begin
         if (rows[i].we) wbXfer(1'b1, rows[i].adr, rows[i].sel, rows[i].dat, rows[i].dat);
         else rdChk("row read", rows[i].adr, 32'hFFFFFFFF, rows[i].dat);
      end
      $display("Test registers done");
      check("clkGateOn", 32'h1, {31'h0, clkGateOn});
      rxBusy <= 1'b1;
      cycles(3);
      check("clkGateOn", 32'h0, {31'h0, clkGateOn});
      rxBusy <= 1'b0;
      baudClkStable <= 1'b0;
      cycles(2);
      rdChk("bclk ready", ufc_pkg::OFS_CTRL, 32'h00080000, 32'h0);
      baudClkStable <= 1'b1;
      $display("Test gating done");
      for (int i = 0; i < 4; i++) begin
         wr(ufc_pkg::OFS_CTRL, flCtrl[i]);
         wr(ufc_pkg::OFS_INT_EN, flEn[i]);
         cycles(6);
         wr(ufc_pkg::OFS_INT_FLAGS, 32'h00000020);
         hold <= ~hold;
         cycles(10);
         check("irq", {31'h0, flExp[i][5] & flEn[i][5]}, {31'h0, irq});
         rdChk("pin cts", ufc_pkg::OFS_PIN_CTRL, 32'h1, {31'h0, hold});
         rdChk("cts flag", ufc_pkg::OFS_INT_FLAGS, 32'h20, flExp[i]);
         rdChk("cts flag kept", ufc_pkg::OFS_INT_FLAGS, 32'h20, flExp[i]);
         wr(ufc_pkg::OFS_INT_FLAGS, 32'h00000020);
         rdChk("cts flag cleared", ufc_pkg::OFS_INT_FLAGS, 32'h20, 32'h0);
      end
      $display("Test cts change done");
      wr(ufc_pkg::OFS_PIN_CTRL, 32'h0);
      cycles(2);
      check("rtsPin_n", 32'h0, {31'h0, rtsPin_n});
      wr(ufc_pkg::OFS_PIN_CTRL, 32'h2);
      rdChk("pin rts", ufc_pkg::OFS_PIN_CTRL, 32'h2, 32'h2);
      check("rtsPin_n", 32'h1, {31'h0, rtsPin_n});
      for (int i = 0; i < 5; i++) begin
         wr(ufc_pkg::OFS_CTRL, rtCtrl[i]);
         rxLevel <= rtLvl[i];
         cycles(3);
         check("rtsPin_n auto", {31'h0, rtExp[i]}, {31'h0, rtsPin_n});
      end
      rxLevel <= 4'h0;
      $display("Test rts done");
      hold <= 1'b1;
      wr(ufc_pkg::OFS_INT_EN, 32'h0);
      wr(ufc_pkg::OFS_CTRL, 32'h0000A000);
      cycles(8);
      txQueueValid <= 1'b1;
      cycles(30);
      check("starts held", 32'h0, startCnt);
      hold <= 1'b0;
      cycles(200);
      check("starts until full", 32'h3, startCnt);
      stall <= 1'b0;
      cycles(200);
      check("starts resumed", 32'h1, {31'h0, startCnt > 3});
      txQueueValid <= 1'b0;
      check("irq", 32'h0, {31'h0, irq});
      $display("Test pacing done");
      cycles(2 * SHIFT_LEN);
      periphReset <= 1'b1;
      @(posedge core_clk);
      periphReset <= 1'b0;
      rdChk("ctrl after reset", ufc_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h80);
      rdChk("divisor after reset", ufc_pkg::OFS_BAUD_DIV, 32'hFFFFFFFF, 32'h0);
      $display("Test peripheral reset done");
      testDone();
   end
endmodule : tb_ufc_flow_ctrl
`default_nettype wire
